// ===== verilog/aia_defs.svh
// register indices, field positions and reset values of the alarm interrupt aggregator
// assumes 32-bit apb data with one register per aligned word (byte address = index * 4)
`ifndef AIA_DEFS_SVH
`define AIA_DEFS_SVH
// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define AIA_IDX_CTRL 10'h014
`define AIA_IDX_CPU_MASK 10'h016
`define AIA_IDX_RX_MASK 10'h017
`define AIA_IDX_TXF_MASK 10'h018
`define AIA_IDX_TRF_MASK 10'h019
`define AIA_IDX_SUMMARY 10'h020
`define AIA_IDX_MASTER 10'h021
`define AIA_IDX_A_ALM0 10'h022
`define AIA_IDX_A_ALM1 10'h024
`define AIA_IDX_B_ALM0 10'h026
`define AIA_IDX_B_ALM1 10'h028
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define AIA_HW_IRQ_EN_BIT 0
`define AIA_CPU_EN_BIT 0
`define AIA_SUM_BIT 7
`define AIA_EXT_BIT 6
`define AIA_FIRST_BIT 5
`define AIA_SECOND_BIT 4
`define AIA_TX_ALM_LSB 4
`define AIA_EMBEDDED_OVERHEAD_PROCESSOR_BIT_HI 7
`define AIA_EMBEDDED_OVERHEAD_PROCESSOR_BIT_MID 6
`define AIA_EMBEDDED_OVERHEAD_PROCESSOR_BIT_LO 4
`define AIA_MASK_RST 8'h00
`define AIA_MASTER_RST 7'h00
`define AIA_ALM_RST 8'h00
`endif

// ===== verilog/aia_pkg.sv
// types shared by the alarm interrupt aggregator
// assumes port alarm inputs are already latched by their own registers
package aia_pkg;
  // ----------------------------------------------------------------
  // latched alarms of one port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_first;
    logic rx_second;
    logic first_remote_fail;
    logic second_remote_fail;
    logic tx_buf_err_first;
    logic tx_buf_err_second;
    logic tx_alarm;
    logic rx_buf_err;
  } aia_port_alarm_type;
  typedef logic [3:0][7:0] aia_side_alarm_type;
endpackage : aia_pkg

// ===== verilog/aia_alarm_interrupt_aggregator.sv
// alarm interrupt aggregator: masks, side alarm latches, summary register and irq lead
// assumes an apb master on i_clk and alarm inputs synchronous to i_clk
//
// Overview of operation
// [R1] summary bit 7 is set while any latched alarm has its masks enabled
// [R2] summary bit 6 shows external clock failure, only with its enable set
// [R3] summary bit 5 shows first-side alarm bits 2..0, gated by first-side enable
// [R4] summary bit 4 shows second-side alarm bits 2..0, gated by second-side enable
// [R5] summary bits 3..0 flag ports 4..1, each gated by its master enable
// [R6] a port bit needs an alarm whose second-level mask bit is also set, except the remote fail alarms, which need none
// [R7] cpu mask bit 0 lets overhead processor alarms raise flag and lead
// [R8] software writes zero to cpu mask bits 7..1
// [R9] receive mask odd bits enable first-side receive alarms per port
// [R10] receive mask even bits enable second-side receive alarms per port
// [R11] transmit buffer mask odd bits enable first-side buffer errors per port
// [R12] transmit buffer mask even bits enable second-side buffer errors per port
// [R13] bits 7..4 of the fifo mask enable transmit alarms of ports 4..1
// [R14] bits 3..0 of the fifo mask enable receive buffer errors of ports 4..1
// [R15] remote fail alarms interrupt even with receive mask bits at zero
// [R16] the irq lead is driven only while the hardware enable bit is 1
// [R17] hardware irq enable is bit 0 of the control register
// [R18] master mask holds ext clock, side and port enables in bits 6..0
// [R19] side alarm registers latch live status until software clears them
// [R20] summary is read-only and follows masked alarms without its own state
// [R21] every mask clears to zero at reset
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "aia_defs.svh"
module aia_alarm_interrupt_aggregator import aia_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire aia_port_alarm_type [3:0] i_port_alarm,
  input wire logic i_ext_clock_fail_alarm,
  input wire aia_side_alarm_type i_side_live,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_interrupt_request_lead,
  output logic o_software_summary_flag
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic ctrl_q, ctrl_d;
  logic cpu_en_q, cpu_en_d;
  logic [7:0] rx_mask_q, rx_mask_d;
  logic [7:0] txf_mask_q, txf_mask_d;
  logic [7:0] trf_mask_q, trf_mask_d;
  logic [6:0] master_q, master_d;
  aia_side_alarm_type alm_q, alm_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;
  logic flag_q, flag_d;
  logic [7:0] summary;
  logic [3:0] port_hit;
  logic first_hit, second_hit, ext_hit, embedded_overhead_processor_hit;
  logic setup, wr_en;
  logic [3:0] side_hit;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [9:0] i);
    reg_addr = ADDR_W'({i, 2'b00});
  endfunction : reg_addr

  // a latched side alarm register that matches the address
  function automatic logic [3:0] side_sel(input logic [ADDR_W-1:0] a);
    side_sel = {a == reg_addr(`AIA_IDX_B_ALM1), a == reg_addr(`AIA_IDX_B_ALM0),
                a == reg_addr(`AIA_IDX_A_ALM1), a == reg_addr(`AIA_IDX_A_ALM0)};
  endfunction : side_sel

  // ----------------------------------------------------------------
  // per-port gating
  // ----------------------------------------------------------------
  generate
    for (genvar p = 0; p < 4; p++) begin : g_port
      always_comb begin
        port_hit[p] = master_q[p] & ( // [R5] [R6]
          (i_port_alarm[p].rx_first & rx_mask_q[2*p+1]) | // [R9]
          (i_port_alarm[p].rx_second & rx_mask_q[2*p]) | // [R10]
          i_port_alarm[p].first_remote_fail | // [R15]
          i_port_alarm[p].second_remote_fail | // [R15]
          (i_port_alarm[p].tx_buf_err_first & txf_mask_q[2*p+1]) | // [R11]
          (i_port_alarm[p].tx_buf_err_second & txf_mask_q[2*p]) | // [R12]
          (i_port_alarm[p].tx_alarm & trf_mask_q[`AIA_TX_ALM_LSB+p]) | // [R13]
          (i_port_alarm[p].rx_buf_err & trf_mask_q[p])); // [R14]
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // summary indication, no state of its own
  // ----------------------------------------------------------------
  always_comb begin
    ext_hit = master_q[`AIA_EXT_BIT] & i_ext_clock_fail_alarm; // [R2]
    first_hit = master_q[`AIA_FIRST_BIT] & (|{alm_q[0][2:0], alm_q[1][2:0]}); // [R3]
    second_hit = master_q[`AIA_SECOND_BIT] & (|{alm_q[2][2:0], alm_q[3][2:0]}); // [R4]
    embedded_overhead_processor_hit = cpu_en_q & (alm_q[3][`AIA_EMBEDDED_OVERHEAD_PROCESSOR_BIT_HI] | alm_q[3][`AIA_EMBEDDED_OVERHEAD_PROCESSOR_BIT_MID] |
                           alm_q[3][`AIA_EMBEDDED_OVERHEAD_PROCESSOR_BIT_LO]); // [R7]
    summary[6:0] = {ext_hit, first_hit, second_hit, port_hit}; // [R20]
    summary[`AIA_SUM_BIT] = (|summary[6:0]) | embedded_overhead_processor_hit; // [R1]
  end

  // ----------------------------------------------------------------
  // apb slave, answers in the first access cycle
  // ----------------------------------------------------------------
  always_comb begin
    setup = i_psel & ~i_penable;
    wr_en = i_psel & i_penable & pready_q & i_pwrite & ~pslverr_q;
    pready_d = setup;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      unique case (i_paddr)
        reg_addr(`AIA_IDX_CTRL): prdata_d[`AIA_HW_IRQ_EN_BIT] = ctrl_q;
        reg_addr(`AIA_IDX_CPU_MASK): prdata_d[`AIA_CPU_EN_BIT] = cpu_en_q;
        reg_addr(`AIA_IDX_RX_MASK): prdata_d[7:0] = rx_mask_q;
        reg_addr(`AIA_IDX_TXF_MASK): prdata_d[7:0] = txf_mask_q;
        reg_addr(`AIA_IDX_TRF_MASK): prdata_d[7:0] = trf_mask_q;
        reg_addr(`AIA_IDX_SUMMARY): prdata_d[7:0] = summary; // [R20]
        reg_addr(`AIA_IDX_MASTER): prdata_d[6:0] = master_q;
        reg_addr(`AIA_IDX_A_ALM0): prdata_d[7:0] = alm_q[0];
        reg_addr(`AIA_IDX_A_ALM1): prdata_d[7:0] = alm_q[1];
        reg_addr(`AIA_IDX_B_ALM0): prdata_d[7:0] = alm_q[2];
        reg_addr(`AIA_IDX_B_ALM1): prdata_d[7:0] = alm_q[3];
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register writes and alarm latches
  // ----------------------------------------------------------------
  always_comb begin
    side_hit = side_sel(i_paddr);
    ctrl_d = ctrl_q;
    cpu_en_d = cpu_en_q;
    rx_mask_d = rx_mask_q;
    txf_mask_d = txf_mask_q;
    trf_mask_d = trf_mask_q;
    master_d = master_q;
    if (wr_en) begin
      unique case (i_paddr)
        reg_addr(`AIA_IDX_CTRL): ctrl_d = i_pwdata[`AIA_HW_IRQ_EN_BIT]; // [R17]
        // upper bits are unused and not stored [R8]
        reg_addr(`AIA_IDX_CPU_MASK): cpu_en_d = i_pwdata[`AIA_CPU_EN_BIT];
        reg_addr(`AIA_IDX_RX_MASK): rx_mask_d = i_pwdata[7:0];
        reg_addr(`AIA_IDX_TXF_MASK): txf_mask_d = i_pwdata[7:0];
        reg_addr(`AIA_IDX_TRF_MASK): trf_mask_d = i_pwdata[7:0];
        reg_addr(`AIA_IDX_MASTER): master_d = i_pwdata[6:0]; // [R18]
        default: ;
      endcase
    end
    // write one to clear; a live alarm in the same cycle wins so none is lost
    for (int s = 0; s < 4; s++) begin
      alm_d[s] = alm_q[s] | i_side_live[s]; // [R19]
      if (wr_en && side_hit[s]) begin
        alm_d[s] = (alm_q[s] & ~i_pwdata[7:0]) | i_side_live[s]; // [R19]
      end
    end
    irq_d = ctrl_q & summary[`AIA_SUM_BIT]; // [R16]
    flag_d = summary[`AIA_SUM_BIT]; // [R1]
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= 1'b0;
      cpu_en_q <= 1'b0; // [R21]
      rx_mask_q <= `AIA_MASK_RST; // [R21]
      txf_mask_q <= `AIA_MASK_RST; // [R21]
      trf_mask_q <= `AIA_MASK_RST; // [R21]
      master_q <= `AIA_MASTER_RST; // [R21]
      alm_q <= {4{`AIA_ALM_RST}};
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      cpu_en_q <= cpu_en_d;
      rx_mask_q <= rx_mask_d;
      txf_mask_q <= txf_mask_d;
      trf_mask_q <= trf_mask_d;
      master_q <= master_d;
      alm_q <= alm_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
      flag_q <= flag_d;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_interrupt_request_lead = irq_q;
  assign o_software_summary_flag = flag_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_irq_needs_enable: assert property ( // [R16]
    @(posedge i_clk) disable iff (!i_nrst)
    o_interrupt_request_lead |-> $past(ctrl_q))
    else $error("irq lead high without hardware enable");

  a_irq_follows_sum: assert property ( // [R17]
    @(posedge i_clk) disable iff (!i_nrst)
    (ctrl_q && summary[`AIA_SUM_BIT]) |=> o_interrupt_request_lead)
    else $error("irq lead missed an enabled summary");

  a_flag_tracks_sum: assert property ( // [R1]
    @(posedge i_clk) disable iff (!i_nrst)
    ##1 o_software_summary_flag == $past(|summary[6:0] | embedded_overhead_processor_hit))
    else $error("summary flag does not follow masked alarms");

  a_ext_gated: assert property ( // [R2]
    @(posedge i_clk) disable iff (!i_nrst)
    !master_q[`AIA_EXT_BIT] |-> !summary[`AIA_EXT_BIT])
    else $error("ext clock indication with enable clear");

  a_first_side: assert property ( // [R3]
    @(posedge i_clk) disable iff (!i_nrst)
    (master_q[`AIA_FIRST_BIT] && alm_q[1][2]) |-> summary[`AIA_FIRST_BIT])
    else $error("first-side alarm not indicated");

  a_second_side: assert property ( // [R4]
    @(posedge i_clk) disable iff (!i_nrst)
    (master_q[`AIA_SECOND_BIT] && alm_q[2][0]) |-> summary[`AIA_SECOND_BIT])
    else $error("second-side alarm not indicated");

  a_port_master: assert property ( // [R5]
    @(posedge i_clk) disable iff (!i_nrst)
    (summary[3:0] & ~master_q[3:0]) == 4'h0)
    else $error("port indication with master enable clear");

  a_embedded_overhead_processor_gated: assert property ( // [R7]
    @(posedge i_clk) disable iff (!i_nrst)
    (!cpu_en_q && summary[6:0] == 7'h00) |-> !summary[`AIA_SUM_BIT])
    else $error("processor alarm passed a clear mask");

  a_remote_fail: assert property ( // [R15]
    @(posedge i_clk) disable iff (!i_nrst)
    (master_q[0] && i_port_alarm[0].first_remote_fail) |-> summary[0])
    else $error("remote fail alarm blocked");

  a_latch_holds: assert property ( // [R19]
    @(posedge i_clk) disable iff (!i_nrst)
    (alm_q[0][0] && !(wr_en && side_hit[0])) |=> alm_q[0][0])
    else $error("latched alarm lost without a clear");

  a_pready_single: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");

  a_rx_first_mask: assert property ( // [R9]
    @(posedge i_clk) disable iff (!i_nrst)
    (master_q[0] && rx_mask_q[1] && i_port_alarm[0].rx_first) |-> summary[0])
    else $error("first-side receive alarm not indicated");

  a_rx_second_mask: assert property ( // [R10]
    @(posedge i_clk) disable iff (!i_nrst)
    (master_q[3] && rx_mask_q[6] && i_port_alarm[3].rx_second) |-> summary[3])
    else $error("second-side receive alarm not indicated");

  a_txbuf_first_mask: assert property ( // [R11]
    @(posedge i_clk) disable iff (!i_nrst)
    (master_q[1] && txf_mask_q[3] && i_port_alarm[1].tx_buf_err_first) |-> summary[1])
    else $error("first-side transmit buffer error not indicated");

  a_txbuf_second_mask: assert property ( // [R12]
    @(posedge i_clk) disable iff (!i_nrst)
    (master_q[2] && txf_mask_q[4] && i_port_alarm[2].tx_buf_err_second) |-> summary[2])
    else $error("second-side transmit buffer error not indicated");

  a_tx_alarm_mask: assert property ( // [R13]
    @(posedge i_clk) disable iff (!i_nrst)
    (master_q[3] && trf_mask_q[7] && i_port_alarm[3].tx_alarm) |-> summary[3])
    else $error("transmit alarm not indicated");

  a_rxbuf_err_mask: assert property ( // [R14]
    @(posedge i_clk) disable iff (!i_nrst)
    (master_q[0] && trf_mask_q[0] && i_port_alarm[0].rx_buf_err) |-> summary[0])
    else $error("receive buffer error not indicated");

  a_port_quiet: assert property ( // [R6]
    @(posedge i_clk) disable iff (!i_nrst)
    (i_port_alarm[0] == '0) |-> !summary[0])
    else $error("port indication without any port alarm");

  a_flag_falls: assert property ( // [R20]
    @(posedge i_clk) disable iff (!i_nrst)
    !summary[`AIA_SUM_BIT] |=> !o_software_summary_flag)
    else $error("summary flag stayed high after alarms cleared");

  a_lead_falls: assert property ( // [R16]
    @(posedge i_clk) disable iff (!i_nrst)
    !summary[`AIA_SUM_BIT] |=> !o_interrupt_request_lead)
    else $error("irq lead stayed high after alarms cleared");
endmodule : aia_alarm_interrupt_aggregator

// ===== tb/aia_host_model.sv
// apb host model for the alarm interrupt aggregator bench
// assumes a slave on i_clk that answers with pready; no pslverr retry
`timescale 1ns/100ps
module aia_host_model #(
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [ADDR_W-1:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr
);
  // ----------------------------------------------------------------
  // bus cycle
  // ----------------------------------------------------------------
  logic hung = 1'b0;
  logic err = 1'b0;
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = '0;
    o_pwdata = '0;
  end
  // bounded wait so a dead slave ends the run instead of hanging it
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= (a == 'h58) ? (d & 32'h1) : d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 16);
    hung = (i_pready !== 1'b1);
    q = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask : xfer
endmodule : aia_host_model

// ===== tb/alarm_interrupt_aggregator_tb.sv
// self-checking bench of the alarm interrupt aggregator
// assumes the apb host model and the defs header on the include path
`timescale 1ns/100ps
`include "aia_defs.svh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module alarm_interrupt_aggregator_tb import aia_pkg::*; ;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTL = 12'(`AIA_IDX_CTRL * 4);
  localparam logic [11:0] A_CPU = 12'(`AIA_IDX_CPU_MASK * 4);
  localparam logic [11:0] A_RX = 12'(`AIA_IDX_RX_MASK * 4);
  localparam logic [11:0] A_TXF = 12'(`AIA_IDX_TXF_MASK * 4);
  localparam logic [11:0] A_TRF = 12'(`AIA_IDX_TRF_MASK * 4);
  localparam logic [11:0] A_SUM = 12'(`AIA_IDX_SUMMARY * 4);
  localparam logic [11:0] A_MST = 12'(`AIA_IDX_MASTER * 4);
  localparam logic [11:0] A_L0 = 12'(`AIA_IDX_A_ALM0 * 4);
  logic clk = 1'b0;
  logic nrst = 1'b0;
  aia_port_alarm_type [3:0] port_alm = '0;
  logic ext_alm = 1'b0;
  aia_side_alarm_type side_live = '0;
  logic psel, penable, pwrite, pready, pslverr, lead, flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int fails = 0;
  int checked = 0;
  always #50 clk = ~clk;
  aia_alarm_interrupt_aggregator #(.ADDR_W(12)) DUT (.i_clk(clk), .i_nrst(nrst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_port_alarm(port_alm), .i_ext_clock_fail_alarm(ext_alm),
    .i_side_live(side_live), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_interrupt_request_lead(lead), .o_software_summary_flag(flag));
  aia_host_model #(.ADDR_W(12)) host (.i_clk(clk), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    host.xfer(wr, a, d, q);
    if (host.hung) begin
      fails++;
      summarize();
    end
  endtask : acc
  task automatic sum_is(input logic [31:0] e);
    acc(1'b0, A_SUM, 32'h0);
    `CHK("summary", e, q)
  endtask : sum_is
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [11:0] regs[6] = '{A_CTL, A_CPU, A_RX, A_TXF, A_TRF, A_MST};
    foreach (regs[i]) begin
      acc(1'b0, regs[i], 32'h0);
      `CHK("mask after reset", 32'h0, q)
    end
    acc(1'b0, 12'h3fc, 32'h0);
    `CHK("unmapped error", 1'b1, host.err)
    sum_is(32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ports();
    logic [11:0] ad;
    int b;
    acc(1'b1, A_MST, 32'h0f);
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 8; k++) begin
        @(posedge clk);
        port_alm[p] <= aia_port_alarm_type'(8'h01 << k);
        sum_is((k == 5 || k == 4) ? 32'h80 | (32'h1 << p) : 32'h0);
        if (k != 5 && k != 4) begin
          ad = (k > 5) ? A_RX : (k > 1) ? A_TXF : A_TRF;
          b = (k == 1) ? 4 + p : (k == 0) ? p : 2 * p + (k % 2);
          acc(1'b1, ad, 32'h1 << b);
          sum_is(32'h80 | (32'h1 << p));
          acc(1'b1, ad, 32'h0);
        end
      end
      acc(1'b1, A_RX, 32'hff);
      acc(1'b1, A_MST, 32'h0f & ~(32'h1 << p));
      sum_is(32'h0);
      acc(1'b1, A_MST, 32'h0f);
      acc(1'b1, A_RX, 32'h0);
      @(posedge clk);
      port_alm[p] <= '0;
    end
    acc(1'b1, A_MST, 32'h0);
    $display("test ports done");
  endtask : t_ports
  task automatic t_side();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      side_live[i] <= 8'h01 << (i % 3);
      @(posedge clk);
      side_live <= '0;
      sum_is(32'h0);
      acc(1'b1, A_MST, 32'h30);
      sum_is(i < 2 ? 32'ha0 : 32'h90);
      acc(1'b1, A_L0 + 12'(8 * i), 32'hff);
      sum_is(32'h0);
      acc(1'b1, A_MST, 32'h0);
    end
    @(posedge clk);
    ext_alm <= 1'b1;
    sum_is(32'h0);
    acc(1'b1, A_MST, 32'h40);
    sum_is(32'hc0);
    @(posedge clk);
    ext_alm <= 1'b0;
    sum_is(32'h0);
    acc(1'b1, A_MST, 32'h0);
    $display("test side done");
  endtask : t_side
  task automatic t_irq();
    @(posedge clk);
    side_live[3] <= 8'hd0;
    @(posedge clk);
    side_live <= '0;
    sum_is(32'h0);
    acc(1'b1, A_CPU, 32'h1);
    acc(1'b0, A_CPU, 32'h0);
    `CHK("cpu mask", 32'h1, q)
    sum_is(32'h80);
    `CHK("flag", 1'b1, flag)
    `CHK("lead off", 1'b0, lead)
    acc(1'b1, A_CTL, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("lead on", 1'b1, lead)
    acc(1'b1, A_CPU, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("lead masked", 1'b0, lead)
    `CHK("flag masked", 1'b0, flag)
    $display("test irq done");
  endtask : t_irq
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_ports();
    t_side();
    t_irq();
    summarize();
  end
endmodule : alarm_interrupt_aggregator_tb
